// ---- backlight_target.sv ----
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
// Summary of operation
// - Overvoltage stops switching until hysteresis release
// - Hardware enable pin high lets device operate
// - Enable low disables inputs, resets all registers
// - Overheat halts switching, registers keep contents
// - Shutdown when pin low or enable bit zero
// - Register-only mode uses brightness code, ignores duty
// - Mapping select bit picks linear or exponential
// - PWM mode scales current by input duty
// - Ambient mode takes code from zone targets
// - Simple mode: active over 2 ms turns on
// - Simple mode: inactive over 2 ms shuts down
// - Start and stop detected on data edges
// - Busy from start to stop; repeated start same
// - Host changes data only while clock low
// - Address plus direction; answer own address only
// - Write: register address byte, then data byte
// - Bytes are eight bits, MSB first
// - Device pulls data low on ninth pulse
// - Eight-bit registers reached over serial link
// - Interrupt pulls low on zone change, read clears
// - Configuration 0x10 resets 0xB0, brightness 0xA0 resets 0x7F
// - Unmapped register addresses read 0xFF; unused zone register bits read zero
module backlight_target
   import bl_pkg::*;
#(
   parameter int HOLD_CYCLES = HOLD_CYC
) (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   i2c_link_if.device       link,
   input  wire logic        hw_enable_pin,
   input  wire logic        pwm_in,
   input  wire logic        ovp_trip,
   input  wire logic        ovp_release,
   input  wire logic        therm_trip,
   input  wire logic        therm_release,
   input  wire logic        zone_event,
   input  wire logic [2:0]  zone_in,
   output logic             boost_switch_en,
   output logic             sink_en,
   output logic [6:0]       led_code,
   output logic [2:0]       full_scale_sel,
   output logic             mapping_select_bit,
   output logic             int_o,
   output logic             int_oe
);

   typedef enum logic [4:0] {
      T_IDLE = 5'b00001,
      T_RX   = 5'b00010,
      T_ACK  = 5'b00100,
      T_TX   = 5'b01000,
      T_TACK = 5'b10000
   } tstate_t;

   localparam logic [17:0] HOLD_LIM = 18'(HOLD_CYCLES);

   // ****************************************************************
   // Serial target
   // ****************************************************************
   logic       rst;
   logic       scl_q;
   logic       sda_q;
   tstate_t    st_q;
   tstate_t    st_d;
   logic [3:0] bit_q;
   logic [3:0] bit_d;
   logic [7:0] sh_q;
   logic [7:0] sh_d;
   logic [1:0] byte_q;
   logic [1:0] byte_d;
   logic       rd_q;
   logic       rd_d;
   logic [7:0] ptr_q;
   logic [7:0] ptr_d;
   logic       oe_q;
   logic       oe_d;
   logic       wr;
   logic       fetch;
   logic [7:0] regs_q [NREG];
   logic       zone_flag_q;
   logic [2:0] zone_q;

   assign rst = !aresetn || !hw_enable_pin;

   wire scl_rise = link.scl && !scl_q;
   wire scl_fall = !link.scl && scl_q;
   wire start_c  = link.scl && scl_q && sda_q && !link.sda;
   wire stop_c   = link.scl && scl_q && !sda_q && link.sda;

   wire [3:0] ptr_ix  = reg_index(ptr_q);
   wire [3:0] wr_ix   = reg_index(ptr_q);
   wire [7:0] zone_rd = {4'h0, zone_flag_q, zone_q};
   wire [7:0] rdata   = (ptr_q == RA_ZONE) ? zone_rd :
                        (ptr_ix == IX_NONE) ? 8'hFF : regs_q[ptr_ix];

   always_ff @(posedge aclk) begin
      scl_q <= link.scl;
      sda_q <= link.sda;
   end

   always_comb begin
      st_d   = st_q;
      bit_d  = bit_q;
      sh_d   = sh_q;
      byte_d = byte_q;
      rd_d   = rd_q;
      ptr_d  = ptr_q;
      oe_d   = oe_q;
      wr     = 1'b0;
      fetch  = 1'b0;
      if (start_c) begin
         st_d   = T_RX;
         bit_d  = 4'h0;
         byte_d = 2'h0;
         oe_d   = 1'b0;
      end else if (stop_c) begin
         st_d = T_IDLE;
         oe_d = 1'b0;
      end else begin
         case (st_q)
            T_RX: begin
               if (scl_rise) begin
                  sh_d  = {sh_q[6:0], link.sda};
                  bit_d = bit_q + 4'h1;
               end else if (scl_fall && bit_q == 4'h8) begin
                  bit_d  = 4'h0;
                  byte_d = (byte_q == 2'h2) ? 2'h2 : byte_q + 2'h1;
                  st_d   = T_ACK;
                  oe_d   = 1'b1;
                  if (byte_q == 2'h0) begin
                     rd_d = sh_q[0];
                     if (sh_q[7:1] != TARGET_ADDR) begin
                        st_d = T_IDLE;
                        oe_d = 1'b0;
                     end
                  end else if (byte_q == 2'h1) begin
                     ptr_d = sh_q;
                  end else begin
                     wr = 1'b1;
                  end
               end
            end
            T_ACK: begin
               if (scl_fall) begin
                  oe_d = 1'b0;
                  st_d = T_RX;
                  if (rd_q && byte_q == 2'h1) begin
                     st_d  = T_TX;
                     sh_d  = rdata;
                     oe_d  = !rdata[7];
                     bit_d = 4'h1;
                     fetch = 1'b1;
                  end
               end
            end
            T_TX: begin
               if (scl_fall) begin
                  if (bit_q == 4'h8) begin
                     oe_d = 1'b0;
                     st_d = T_TACK;
                  end else begin
                     sh_d  = {sh_q[6:0], 1'b1};
                     oe_d  = !sh_q[6];
                     bit_d = bit_q + 4'h1;
                  end
               end
            end
            T_TACK: begin
               if (scl_rise) begin
                  if (link.sda) st_d = T_IDLE;
                  else bit_d = 4'h0;
               end else if (scl_fall && bit_q == 4'h0) begin
                  st_d  = T_TX;
                  sh_d  = rdata;
                  oe_d  = !rdata[7];
                  bit_d = 4'h1;
                  fetch = 1'b1;
               end
            end
            T_IDLE: begin
            end
            default: st_d = T_IDLE;
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      if (rst) begin
         st_q   <= T_IDLE;
         bit_q  <= 4'h0;
         sh_q   <= 8'h00;
         byte_q <= 2'h0;
         rd_q   <= 1'b0;
         ptr_q  <= 8'h00;
         oe_q   <= 1'b0;
      end else begin
         st_q   <= st_d;
         bit_q  <= bit_d;
         sh_q   <= sh_d;
         byte_q <= byte_d;
         rd_q   <= rd_d;
         ptr_q  <= ptr_d;
         oe_q   <= oe_d;
      end
   end

   assign link.dev_sda_o  = 1'b0;
   assign link.dev_sda_oe = oe_q;

   // ****************************************************************
   // Register file
   // ****************************************************************
   always_ff @(posedge aclk) begin
      if (rst) begin
         for (int i = 0; i < NREG; i++) regs_q[i] <= REG_RST[i];
      end else if (wr && wr_ix != IX_NONE) begin
         regs_q[wr_ix] <= sh_q;
      end
   end

   always_ff @(posedge aclk) begin
      if (rst) begin
         zone_flag_q <= 1'b0;
         zone_q      <= 3'h0;
      end else if (zone_event) begin
         zone_flag_q <= 1'b1;
         zone_q      <= zone_in;
      end else if (fetch && ptr_q == RA_ZONE) begin
         zone_flag_q <= 1'b0;
      end
   end

   // ****************************************************************
   // Operating modes
   // ****************************************************************
   logic        ovp_hold_q;
   logic        therm_hold_q;
   logic        simple_on_q;
   logic [17:0] hold_cnt_q;

   wire [7:0] gen      = regs_q[IX_GEN];
   wire [7:0] ambient_light_sensing      = regs_q[IX_ALS];
   wire dev_en         = hw_enable_pin && gen[GEN_EN];
   wire simple_mode    = dev_en && gen[GEN_SIMPLE] && gen[GEN_PWM];
   wire pwm_mode       = dev_en && gen[GEN_PWM] && !gen[GEN_SIMPLE];
   wire als_mode       = dev_en && ambient_light_sensing[ALS_CC_EN] && ambient_light_sensing[ALS_IN_EN];
   wire pwm_act        = pwm_in ^ gen[GEN_POL];
   wire [2:0] zsel     = (zone_q > ZONE_MAX) ? ZONE_MAX : zone_q;
   wire [7:0] zt_code  = regs_q[IX_ZT0 + {1'b0, zsel}];
   wire led_on         = dev_en && (!simple_mode || simple_on_q);

   always_ff @(posedge aclk) begin
      if (!aresetn) ovp_hold_q <= 1'b0;
      else if (ovp_trip) ovp_hold_q <= 1'b1;
      else if (ovp_release) ovp_hold_q <= 1'b0;
   end

   // Held on the main reset only, so a thermal event never clears registers.
   // thermal hysteresis hold
   always_ff @(posedge aclk) begin
      if (!aresetn) therm_hold_q <= 1'b0;
      else if (therm_trip) therm_hold_q <= 1'b1;
      else if (therm_release) therm_hold_q <= 1'b0;
   end

   always_ff @(posedge aclk) begin
      if (rst || !simple_mode || pwm_act == simple_on_q) begin
         hold_cnt_q <= 18'h00000;
         if (rst || !simple_mode) simple_on_q <= 1'b0;
      end else if (hold_cnt_q == HOLD_LIM) begin
         hold_cnt_q  <= 18'h00000;
         simple_on_q <= !simple_on_q;
      end else begin
         hold_cnt_q <= hold_cnt_q + 18'h00001;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         boost_switch_en    <= 1'b0;
         sink_en            <= 1'b0;
         led_code           <= 7'h00;
         full_scale_sel     <= 3'h0;
         mapping_select_bit <= 1'b0;
         int_oe             <= 1'b0;
      end else begin
         boost_switch_en    <= led_on && !ovp_hold_q && !therm_hold_q;
         sink_en            <= led_on && (!pwm_mode || pwm_act);
         led_code           <= als_mode ? zt_code[6:0] : regs_q[IX_BRT][6:0];
         full_scale_sel     <= gen[GEN_FS+2:GEN_FS];
         mapping_select_bit <= gen[GEN_MAP];
         int_oe             <= zone_flag_q;
      end
   end

   assign int_o = 1'b0;

endmodule

// ---- bl_pkg.sv ----
package bl_pkg;

   // ****************************************************************
   // Timing
   // ****************************************************************
   localparam int CLK_NS    = 8;
   localparam int HOLD_NS   = 2000000;
   localparam int HOLD_CYC  = (HOLD_NS + CLK_NS - 1) / CLK_NS;
   localparam int QTR_NS    = 2500;
   localparam int QTR_CYC   = (QTR_NS + CLK_NS - 1) / CLK_NS;

   // Target address value is arbitrary.
   localparam logic [6:0] TARGET_ADDR = 7'h2A;

   // ****************************************************************
   // Device register map
   // ****************************************************************
   localparam int         NREG    = 14;
   localparam logic [7:0] RA_GEN  = 8'h10;
   localparam logic [7:0] RA_ALS  = 8'h20;
   localparam logic [7:0] RA_RAMP = 8'h30;
   localparam logic [7:0] RA_ZONE = 8'h40;
   localparam logic [7:0] RA_RES  = 8'h41;
   localparam logic [7:0] RA_BRT  = 8'hA0;
   localparam logic [7:0] RA_ZB0  = 8'h60;
   localparam logic [7:0] RA_ZT0  = 8'h70;
   localparam logic [3:0] IX_GEN  = 4'h0;
   localparam logic [3:0] IX_ALS  = 4'h1;
   localparam logic [3:0] IX_BRT  = 4'h4;
   localparam logic [3:0] IX_ZT0  = 4'h9;
   localparam logic [3:0] IX_NONE = 4'hF;
   localparam logic [7:0] REG_RST [NREG] = '{8'hB0, 8'h2C, 8'h00, 8'h00, 8'h7F,
                                             8'h33, 8'h66, 8'h99, 8'hCC,
                                             8'h19, 8'h33, 8'h4C, 8'h66, 8'h7F};
   localparam int GEN_EN     = 0;
   localparam int GEN_MAP    = 1;
   localparam int GEN_FS     = 2;
   localparam int GEN_PWM    = 5;
   localparam int GEN_POL    = 6;
   localparam int GEN_SIMPLE = 7;
   localparam int ALS_IN_EN  = 3;
   localparam int ALS_CC_EN  = 4;
   localparam logic [2:0] ZONE_MAX = 3'h4;

   // ****************************************************************
   // Host controller register map
   // ****************************************************************
   localparam logic [7:0] HA_CMD     = 8'h00;
   localparam logic [7:0] HA_STAT    = 8'h04;
   localparam int         CMD_RD     = 16;
   localparam logic [1:0] RESP_OKAY  = 2'h0;
   localparam logic [1:0] RESP_SLV   = 2'h2;

   function automatic logic [3:0] reg_index(input logic [7:0] a);
      logic [3:0] ix;
      ix = IX_NONE;
      case (a)
         RA_GEN:  ix = 4'h0;
         RA_ALS:  ix = 4'h1;
         RA_RAMP: ix = 4'h2;
         RA_RES:  ix = 4'h3;
         RA_BRT:  ix = 4'h4;
         default: begin
            if (a >= RA_ZB0 && a <= RA_ZB0 + 8'h03) ix = 4'h5 + a[3:0];
            if (a >= RA_ZT0 && a <= RA_ZT0 + 8'h04) ix = 4'h9 + a[3:0];
         end
      endcase
      return ix;
   endfunction

endpackage

// ---- i2c_link_if.sv ----
`timescale 1ns/1ns
interface i2c_link_if;
   logic host_scl_o;
   logic host_scl_oe;
   logic host_sda_o;
   logic host_sda_oe;
   logic dev_sda_o;
   logic dev_sda_oe;
   logic scl;
   logic sda;

   // Open-drain wired-AND with pull-ups.
   assign scl = host_scl_oe ? host_scl_o : 1'b1;
   assign sda = (host_sda_oe ? host_sda_o : 1'b1) & (dev_sda_oe ? dev_sda_o : 1'b1);

   modport host   (output host_scl_o, host_scl_oe, host_sda_o, host_sda_oe, input scl, sda);
   modport device (output dev_sda_o, dev_sda_oe, input scl, sda);
endinterface

// ---- i2c_host_ctrl.sv ----
`timescale 1ns/1ns
module i2c_host_ctrl
   import bl_pkg::*;
#(
   parameter int QTR_CYCLES = QTR_CYC
) (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [7:0]  awaddr,
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output logic             wready,
   output logic [1:0]       bresp,
   output logic             bvalid,
   input  wire logic        bready,
   input  wire logic [7:0]  araddr,
   input  wire logic        arvalid,
   output logic             arready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   output logic             rvalid,
   input  wire logic        rready,
   i2c_link_if.host         link
);

   typedef enum logic [3:0] {
      H_IDLE  = 4'b0001,
      H_START = 4'b0010,
      H_BYTE  = 4'b0100,
      H_STOP  = 4'b1000
   } hstate_t;

   localparam logic [9:0] QTR_LIM = 10'(QTR_CYCLES - 1);

   // ****************************************************************
   // Bus slave
   // ****************************************************************
   logic [7:0]  awaddr_q;
   logic [31:0] wdata_q;
   logic [16:0] cmd_q;
   logic [7:0]  rx_q;
   logic        nack_q;
   hstate_t     st_q;
   logic        wstrb_all;

   wire busy    = (st_q != H_IDLE);
   wire wr_now  = !awready && !wready && !bvalid;
   wire wr_ok   = (awaddr_q == HA_CMD) || (awaddr_q == HA_STAT);
   wire go      = wr_now && awaddr_q == HA_CMD && !busy && wstrb_all;
   wire [31:0] stat = {16'h0000, rx_q, 6'h00, nack_q, busy};

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready   <= 1'b1;
         wready    <= 1'b1;
         bvalid    <= 1'b0;
         bresp     <= RESP_OKAY;
         awaddr_q  <= 8'h00;
         wdata_q   <= 32'h00000000;
         wstrb_all <= 1'b0;
      end else begin
         if (awvalid && awready) begin
            awready  <= 1'b0;
            awaddr_q <= awaddr;
         end
         if (wvalid && wready) begin
            wready    <= 1'b0;
            wdata_q   <= wdata;
            wstrb_all <= &wstrb[2:0];
         end
         if (wr_now) begin
            bvalid <= 1'b1;
            bresp  <= wr_ok ? RESP_OKAY : RESP_SLV;
         end
         if (bvalid && bready) begin
            bvalid  <= 1'b0;
            awready <= 1'b1;
            wready  <= 1'b1;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready <= 1'b1;
         rvalid  <= 1'b0;
         rdata   <= 32'h00000000;
         rresp   <= RESP_OKAY;
      end else if (arvalid && arready) begin
         arready <= 1'b0;
         rvalid  <= 1'b1;
         rdata   <= (araddr == HA_STAT) ? stat :
                    (araddr == HA_CMD) ? {15'h0000, cmd_q} : 32'h00000000;
         rresp   <= (araddr == HA_STAT || araddr == HA_CMD) ? RESP_OKAY : RESP_SLV;
      end else if (rvalid && rready) begin
         rvalid  <= 1'b0;
         arready <= 1'b1;
      end
   end

   // ****************************************************************
   // Serial engine
   // ****************************************************************
   logic [9:0] qcnt_q;
   logic [1:0] ph_q;
   logic [2:0] step_q;
   logic [3:0] bit_q;
   logic [7:0] sh_q;
   logic       scl_oe_q;
   logic       sda_oe_q;

   wire rd      = cmd_q[CMD_RD];
   wire tick    = busy && qcnt_q == QTR_LIM;
   wire rx_byte = rd && step_q == 3'h5;
   wire last    = rd ? (step_q == 3'h5) : (step_q == 3'h3);
   wire ack_bad = bit_q == 4'h8 && link.sda && !rx_byte;

   function automatic logic [7:0] host_byte(input logic [2:0] s, input logic [16:0] c);
      case (s)
         3'h1:    return {TARGET_ADDR, 1'b0};
         3'h2:    return c[7:0];
         3'h3:    return c[15:8];
         3'h4:    return {TARGET_ADDR, 1'b1};
         default: return 8'hFF;
      endcase
   endfunction

   wire scl_lvl = (st_q == H_IDLE) || (ph_q == 2'h1) || (ph_q == 2'h2) ||
                  (st_q == H_STOP && ph_q == 2'h3);
   wire sda_lvl = (st_q == H_START) ? !ph_q[1] :
                  (st_q == H_STOP)  ? ph_q[1] :
                  (st_q == H_BYTE)  ? (rx_byte || bit_q == 4'h8 || sh_q[7]) : 1'b1;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_q   <= H_IDLE;
         qcnt_q <= 10'h000;
         ph_q   <= 2'h0;
         step_q <= 3'h0;
         bit_q  <= 4'h0;
         sh_q   <= 8'hFF;
         rx_q   <= 8'h00;
         nack_q <= 1'b0;
         cmd_q  <= 17'h00000;
      end else if (go) begin
         st_q   <= H_START;
         qcnt_q <= 10'h000;
         ph_q   <= 2'h0;
         step_q <= 3'h0;
         nack_q <= 1'b0;
         cmd_q  <= wdata_q[16:0];
      end else if (busy) begin
         qcnt_q <= tick ? 10'h000 : qcnt_q + 10'h001;
         if (tick) ph_q <= ph_q + 2'h1;
         if (tick && ph_q == 2'h1 && st_q == H_BYTE) begin
            if (bit_q != 4'h8) rx_q <= {rx_q[6:0], link.sda};
            else if (ack_bad) nack_q <= 1'b1;
         end
         if (tick && ph_q == 2'h3) begin
            case (st_q)
               H_START: begin
                  st_q   <= H_BYTE;
                  step_q <= step_q + 3'h1;
                  bit_q  <= 4'h0;
                  sh_q   <= host_byte(step_q + 3'h1, cmd_q);
               end
               H_BYTE: begin
                  if (bit_q != 4'h8) begin
                     bit_q <= bit_q + 4'h1;
                     sh_q  <= {sh_q[6:0], 1'b1};
                  end else if (nack_q || last) begin
                     st_q <= H_STOP;
                  end else if (rd && step_q == 3'h2) begin
                     st_q   <= H_START;
                     step_q <= 3'h3;
                  end else begin
                     step_q <= step_q + 3'h1;
                     bit_q  <= 4'h0;
                     sh_q   <= host_byte(step_q + 3'h1, cmd_q);
                  end
               end
               H_STOP:  st_q <= H_IDLE;
               default: st_q <= H_IDLE;
            endcase
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         scl_oe_q <= 1'b0;
         sda_oe_q <= 1'b0;
      end else begin
         scl_oe_q <= !scl_lvl;
         sda_oe_q <= !sda_lvl;
      end
   end

   assign link.host_scl_o  = 1'b0;
   assign link.host_scl_oe = scl_oe_q;
   assign link.host_sda_o  = 1'b0;
   assign link.host_sda_oe = sda_oe_q;

endmodule

// ---- backlight_mode_ctrl_i2c_target_assertions.sv ----
`timescale 1ns/1ns
module backlight_mode_ctrl_i2c_target_assertions (
   input wire logic       aclk,
   input wire logic       aresetn,
   input wire logic       scl,
   input wire logic       sda,
   input wire logic       dev_sda_oe,
   input wire logic       hw_enable_pin,
   input wire logic       ovp_trip,
   input wire logic       therm_trip,
   input wire logic       boost_switch_en,
   input wire logic       sink_en,
   input wire logic [2:0] full_scale_sel
);
   // ****************************************************************
   // Bus state seen from the wire
   // ****************************************************************
   logic scl_q;
   logic sda_q;
   logic busy_q;
   wire  start_w = scl && scl_q && sda_q && !sda;
   wire  stop_w  = scl && scl_q && !sda_q && sda;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   always_ff @(posedge aclk) begin
      scl_q  <= scl;
      sda_q  <= sda;
      busy_q <= aresetn && (start_w || (busy_q && !stop_w));
   end
   sequence s_scl_high;
      scl && $past(scl);
   endsequence
   sequence s_start;
      s_scl_high ##0 $fell(sda);
   endsequence
   property p_start_free; s_start |-> !dev_sda_oe; endproperty
   a_start_free: assert property (p_start_free) else $error("data held at start");
   property p_busy_only; dev_sda_oe |-> busy_q; endproperty
   a_busy_only: assert property (p_busy_only) else $error("drive outside session");
   property p_stable_high; s_scl_high |-> $stable(dev_sda_oe); endproperty
   a_stable_high: assert property (p_stable_high) else $error("data moved in high");
   property p_ack_low; $rose(dev_sda_oe) |-> !scl && !$past(scl); endproperty
   a_ack_low: assert property (p_ack_low) else $error("pull-down not in low");
   property p_ovp_stop; ovp_trip |-> ##2 !boost_switch_en; endproperty
   a_ovp_stop: assert property (p_ovp_stop) else $error("switching during trip");
   property p_therm_stop; therm_trip |-> ##2 !boost_switch_en; endproperty
   a_therm_stop: assert property (p_therm_stop) else $error("switching when hot");
   property p_therm_keep; therm_trip |=> $stable(full_scale_sel); endproperty
   a_therm_keep: assert property (p_therm_keep) else $error("setting lost when hot");
   property p_pin_off; !hw_enable_pin |-> ##2 !sink_en && !boost_switch_en; endproperty
   a_pin_off: assert property (p_pin_off) else $error("on with pin low");
   property p_pin_rst; !hw_enable_pin |-> ##2 full_scale_sel == 3'h4; endproperty
   a_pin_rst: assert property (p_pin_rst) else $error("setting kept with pin low");
endmodule

// ---- backlight_mode_ctrl_i2c_target_tb_top.sv ----
`timescale 1ns/1ns
module backlight_mode_ctrl_i2c_target_tb_top import bl_pkg::*;;
   // ****************************************************************
   // Stimulus and checks
   // ****************************************************************
   logic        aclk = 1'b0, aresetn = 1'b0, hw_enable_pin = 1'b1, pwm_in = 1'b0;
   logic        ovp_trip = 1'b0, ovp_release = 1'b0, therm_trip = 1'b0;
   logic        therm_release = 1'b0, zone_event = 1'b0;
   logic [2:0]  zone_in = 3'h0, full_scale_sel;
   logic [6:0]  led_code;
   logic        boost_switch_en, sink_en, mapping_select_bit, int_o, int_oe;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata, rd_q;
   logic [3:0]  wstrb = 4'hF;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0;
   logic        rready = 1'b0, awready, wready, bvalid, arready, rvalid;
   logic [1:0]  bresp, rresp, rr_q;
   int          failures = 0, checks_done = 0;
   i2c_link_if i_i2c_link_if ();
   backlight_target #(.HOLD_CYCLES(20)) i_backlight_target (.aclk, .aresetn,
      .link(i_i2c_link_if), .hw_enable_pin, .pwm_in, .ovp_trip, .ovp_release, .therm_trip,
      .therm_release, .zone_event, .zone_in, .boost_switch_en, .sink_en, .led_code,
      .full_scale_sel, .mapping_select_bit, .int_o, .int_oe);
   i2c_host_ctrl #(.QTR_CYCLES(20)) i_i2c_host_ctrl (.aclk, .aresetn, .awaddr, .awvalid,
      .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
      .arready, .rdata, .rresp, .rvalid, .rready, .link(i_i2c_link_if));
   backlight_mode_ctrl_i2c_target_assertions i_chk (.aclk, .aresetn,
      .scl(i_i2c_link_if.scl), .sda(i_i2c_link_if.sda),
      .dev_sda_oe(i_i2c_link_if.dev_sda_oe), .hw_enable_pin, .ovp_trip, .therm_trip,
      .boost_switch_en, .sink_en, .full_scale_sel);
   initial begin
      forever #4 aclk = ~aclk;
   end
   task automatic results();
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic hang();
      failures++;
      results();
   endtask
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
         n++;
      end while (bvalid !== 1'b1 && n < 64);
      check("bresp", 32'(RESP_OKAY), 32'(bresp));
      bready <= 1'b0;
      if (n == 64) hang();
      @(posedge aclk);
   endtask
   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      n = 0;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready === 1'b1) arvalid <= 1'b0;
         n++;
      end while (rvalid !== 1'b1 && n < 64);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
      if (n == 64) hang();
      @(posedge aclk);
   endtask
   task automatic i2c_op(input logic [31:0] cmd);
      int n;
      axi_wr(HA_CMD, cmd);
      for (n = 0; n < 1000; n++) begin
         repeat (20) @(posedge aclk);
         axi_rd(HA_STAT, rd_q, rr_q);
         if (rd_q[0] === 1'b0) break;
      end
      if (n == 1000) hang();
   endtask
   task automatic t_defaults();
      check("fs_sel", 32'h4, 32'(full_scale_sel));
      check("map", 32'h0, 32'(mapping_select_bit));
      check("sink", 32'h0, 32'(sink_en));
      axi_rd(8'hFC, rd_q, rr_q);
      check("rresp", 32'(RESP_SLV), 32'(rr_q));
   endtask
   task automatic t_write();
      i2c_op({15'h0, 1'b0, 8'h0F, RA_GEN});
      check("nack", 32'h0, 32'(rd_q[1]));
      check("fs_sel", 32'h3, 32'(full_scale_sel));
      check("map", 32'h1, 32'(mapping_select_bit));
      check("sink", 32'h1, 32'(sink_en));
      check("code", 32'h7F, 32'(led_code));
   endtask
   task automatic t_faults();
      ovp_trip <= 1'b1;
      repeat (3) @(posedge aclk);
      ovp_trip <= 1'b0;
      repeat (2) @(posedge aclk);
      check("boost", 32'h0, 32'(boost_switch_en));
      ovp_release <= 1'b1;
      repeat (3) @(posedge aclk);
      ovp_release <= 1'b0;
      check("boost", 32'h1, 32'(boost_switch_en));
      therm_trip <= 1'b1;
      repeat (3) @(posedge aclk);
      check("boost", 32'h0, 32'(boost_switch_en));
      check("fs_sel", 32'h3, 32'(full_scale_sel));
      therm_trip <= 1'b0;
      therm_release <= 1'b1;
      repeat (3) @(posedge aclk);
      therm_release <= 1'b0;
   endtask
   task automatic t_read();
      i2c_op({15'h0, 1'b1, 8'h00, RA_GEN});
      check("read", 32'h0F, 32'(rd_q[15:8]));
   endtask
   task automatic sink_at(input int n, input logic e);
      repeat (n) @(posedge aclk);
      check("sink", 32'(e), 32'(sink_en));
   endtask
   task automatic t_modes();
      i2c_op({15'h0, 1'b0, 8'h2F, RA_GEN});
      sink_at(0, 1'b0);
      pwm_in <= 1'b1;
      sink_at(3, 1'b1);
      pwm_in <= 1'b0;
      i2c_op({15'h0, 1'b0, 8'hAF, RA_GEN});
      i2c_op({15'h0, 1'b0, 8'h18, RA_ALS});
      pwm_in <= 1'b1;
      sink_at(12, 1'b0);
      sink_at(12, 1'b1);
      pwm_in <= 1'b0;
      sink_at(24, 1'b0);
   endtask
   task automatic t_zone_pin();
      zone_in <= 3'h2;
      zone_event <= 1'b1;
      @(posedge aclk);
      zone_event <= 1'b0;
      repeat (3) @(posedge aclk);
      check("int", 32'h1, 32'(int_oe));
      check("code", 32'h4C, 32'(led_code));
      hw_enable_pin <= 1'b0;
      repeat (2) @(posedge aclk);
      hw_enable_pin <= 1'b1;
      repeat (3) @(posedge aclk);
      check("fs_sel", 32'h4, 32'(full_scale_sel));
      check("sink", 32'h0, 32'(sink_en));
      check("int", 32'h0, 32'(int_oe));
   endtask
   initial begin
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (3) @(posedge aclk);
      t_defaults();
      t_write();
      t_faults();
      t_read();
      t_modes();
      t_zone_pin();
      results();
   end
endmodule
